// ===== lmfc_regs.svh
/*
 * Register offsets, field positions, reset values and timing figures of the
 * LED matrix function-control block.
 * Assumes a 200 MHz core clock and an external serial front end that hands
 * over whole byte reads and writes.
 */
// How it works
// - phase-select bit one shifts the scan on-window by half a period
// - row pull-down code: 000 none, 001-011 only while row off, 1xx always
// - column pull-up code decodes like row pull-down, off-only versus continuous
// - detect-mode 01 runs open detection once into result bytes 03h to 23h
// - detect-mode 10 runs short detection once into the same bytes
// - result bytes read-only, six column flags low, two top bits zero
// - thermal threshold code 00..11 means 140, 120, 100, 90 degrees
// - roll-off scales current to 100, 75, 55 or 30 percent
// - clock-share 11 drives scan clock on sync pin, 10 takes it in
// - clock-share upper bit zero disables sharing, sync pin pulled low
// - spread-enable dithers the clock; range and period apply only then
// - spread range codes give 5, 15, 24, 34 percent deviation
// - spread period codes give 1980, 1200, 820, 660 microseconds
// - writing 0xAE to 2Fh returns every register to default
// - power-up loads defaults so the matrix starts blank
// - eleven rows enabled one at a time, LEDs lit only in own slot
// - slot is 33 us scan, 0.83 us blanking gap, 0.3 us column delay
// - active row switch high while its LEDs are lit, else low
// - each LED on time in 256 steps proportional to its PWM byte
// - detect-mode codes 00/11 idle; each 00-to-detect transition runs once
`ifndef LMFC_REGS_SVH
`define LMFC_REGS_SVH

// ****************************************************************
// offsets
// ****************************************************************
`define LMFC_ADDR_PULL 8'h02
`define LMFC_ADDR_RES_FIRST 8'h03
`define LMFC_ADDR_RES_LAST 8'h23
`define LMFC_ADDR_THERM 8'h24
`define LMFC_ADDR_SPREAD 8'h25
`define LMFC_ADDR_SRST 8'h2F
`define LMFC_SRST_KEY 8'hAE

// ****************************************************************
// reset values
// ****************************************************************
`define LMFC_PULL_RST 8'h33
`define LMFC_THERM_RST 8'h00
`define LMFC_SPREAD_RST 8'h00

// ****************************************************************
// field positions
// ****************************************************************
`define LMFC_PHASE_BIT 7
`define LMFC_RPD_HI 6
`define LMFC_RPD_LO 4
`define LMFC_CPU_HI 2
`define LMFC_CPU_LO 0
`define LMFC_TS_HI 3
`define LMFC_TS_LO 2
`define LMFC_THERMAL_DERATE_HI 1
`define LMFC_THERMAL_DERATE_LO 0
`define LMFC_SYNC_HI 7
`define LMFC_SYNC_LO 6
`define LMFC_SSP_BIT 4
`define LMFC_RNG_HI 3
`define LMFC_RNG_LO 2
`define LMFC_CLT_HI 1
`define LMFC_CLT_LO 0

// ****************************************************************
// timing
// ****************************************************************
`define LMFC_CLK_NS 5
`define LMFC_SCAN_NS 33000
`define LMFC_NOL_NS 830
`define LMFC_CDLY_NS 300
`define LMFC_PWM_STEPS 256
`define LMFC_ROWS 11
`define LMFC_RES_DEPTH 33

`endif

// ===== lmfc_pkg.sv
/*
 * Types and code tables of the LED matrix function-control block.
 * Assumes nothing beyond the register header.
 */
package lmfc_pkg;

  typedef enum logic [2:0] {
    LMFC_SCAN = 3'h1,
    LMFC_GAP = 3'h2,
    LMFC_CDLY = 3'h4
  } lmfc_scan_t;

  typedef enum logic [1:0] {
    LMFC_DET_OFF = 2'h0,
    LMFC_DET_OPEN = 2'h1,
    LMFC_DET_SHORT = 2'h2,
    LMFC_DET_IDLE = 2'h3
  } lmfc_det_t;

  // resistor value in ohms for a pull select code
  function automatic logic [13:0] lmfc_ohm(input logic [2:0] s);
    case (s)
      3'h1: lmfc_ohm = 14'h01F4;
      3'h2: lmfc_ohm = 14'h03E8;
      3'h3: lmfc_ohm = 14'h07D0;
      3'h4: lmfc_ohm = 14'h03E8;
      3'h5: lmfc_ohm = 14'h07D0;
      3'h6: lmfc_ohm = 14'h0FA0;
      3'h7: lmfc_ohm = 14'h1F40;
      default: lmfc_ohm = 14'h0000;
    endcase
  endfunction

  // roll-off threshold in degrees
  function automatic logic [7:0] lmfc_temp(input logic [1:0] s);
    case (s)
      2'h0: lmfc_temp = 8'h8C;
      2'h1: lmfc_temp = 8'h78;
      2'h2: lmfc_temp = 8'h64;
      default: lmfc_temp = 8'h5A;
    endcase
  endfunction

  // output current in percent while rolled off
  function automatic logic [6:0] lmfc_derate(input logic [1:0] s);
    case (s)
      2'h0: lmfc_derate = 7'h64;
      2'h1: lmfc_derate = 7'h4B;
      2'h2: lmfc_derate = 7'h37;
      default: lmfc_derate = 7'h1E;
    endcase
  endfunction

  // spread deviation in plus/minus percent
  function automatic logic [5:0] lmfc_dev(input logic [1:0] s);
    case (s)
      2'h0: lmfc_dev = 6'h05;
      2'h1: lmfc_dev = 6'h0F;
      2'h2: lmfc_dev = 6'h18;
      default: lmfc_dev = 6'h22;
    endcase
  endfunction

  // spread modulation period in microseconds
  function automatic logic [10:0] lmfc_period(input logic [1:0] s);
    case (s)
      2'h0: lmfc_period = 11'h7BC;
      2'h1: lmfc_period = 11'h4B0;
      2'h2: lmfc_period = 11'h334;
      default: lmfc_period = 11'h294;
    endcase
  endfunction

endpackage

// ===== lmfc_mem_if.sv
/*
 * Carrier between the control logic and the detection result memory.
 * Assumes both ends share one clock.
 */
`timescale 1ns/100ps
interface lmfc_mem_if;
  logic wr_en;
  logic [5:0] wr_addr;
  logic [5:0] wr_data;
  logic [5:0] rd_addr;
  logic [5:0] rd_data;
  modport ctrl(output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem(input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// ===== lmfc_result_mem.sv
/*
 * Detection result memory: one six-bit word per result byte.
 * Assumes nothing of the controller's addresses: writes out of range are dropped; reads out of
 * range return zero. Read data come from a register one cycle after the address.
 */
`timescale 1ns/100ps
module lmfc_result_mem
  import lmfc_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // access
  lmfc_mem_if.mem m
);
  `include "lmfc_regs.svh"

  logic [5:0] mem_q [0:`LMFC_RES_DEPTH-1];
  logic [5:0] rd_r;
  wire rd_in_range = m.rd_addr < 6'(`LMFC_RES_DEPTH);
  wire wr_in_range = m.wr_addr < 6'(`LMFC_RES_DEPTH);
  wire [5:0] rd_nxt = rd_in_range ? mem_q[m.rd_addr] : 6'h00;

  // array has no reset; validity is tracked by the controller
  always_ff @(posedge core_clk_i) begin
    if (m.wr_en && wr_in_range) begin
      mem_q[m.wr_addr] <= m.wr_data;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_r <= 6'h00;
    end else begin
      rd_r <= rd_nxt;
    end
  end

  assign m.rd_data = rd_r;
endmodule

// ===== lmfc_top.sv
/*
 * LED matrix function control: register port, row scan with PWM columns,
 * pull selection, one-shot open/short detection, thermal, sync and spread.
 * Assumes a serial front end giving one-cycle byte read/write strobes and the
 * PWM bytes of the row named on scan_row_o; analog parts sit outside.
 */
`timescale 1ns/100ps
`include "lmfc_regs.svh"
module lmfc_top
  import lmfc_pkg::*;
#(
  parameter int unsigned ROW_SLOT_CYC = `LMFC_SCAN_NS / `LMFC_CLK_NS
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // configuration and brightness
  input wire logic [1:0] detect_mode_i,
  input wire logic [143:0] pwm_row_i,
  output logic [3:0] scan_row_o,
  // matrix drive
  output logic [10:0] row_switch_o,
  output logic [17:0] column_sink_o,
  output logic [10:0] row_pd_en_o,
  output logic [13:0] row_pd_ohm_o,
  output logic [17:0] col_pu_en_o,
  output logic [13:0] col_pu_ohm_o,
  // detection
  input wire logic [17:0] led_fault_i,
  output logic [1:0] detect_kind_o,
  output logic detect_busy_o,
  // thermal
  input wire logic temp_hot_i,
  output logic [7:0] thermal_limit_o,
  output logic [6:0] current_scale_o,
  // chip sync pin
  input wire logic sync_i,
  output logic sync_o,
  output logic sync_oe_o,
  output logic sync_pd_en_o,
  // spread spectrum
  output logic spread_en_o,
  output logic [5:0] spread_dev_o,
  output logic [10:0] spread_period_o
);

  localparam int SCAN_CYC = ROW_SLOT_CYC;
  localparam int NOL_CYC = (`LMFC_NOL_NS + `LMFC_CLK_NS - 1) / `LMFC_CLK_NS;
  localparam int CDLY_CYC = (`LMFC_CDLY_NS + `LMFC_CLK_NS - 1) / `LMFC_CLK_NS;
  localparam int PWM_DIV = (SCAN_CYC / `LMFC_PWM_STEPS) < 1 ? 1 : SCAN_CYC / `LMFC_PWM_STEPS;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0] pull_r, therm_r, spread_r;
  logic rd_res_r, res_vld_r, rvalid_r;
  logic [7:0] rd_val_r;
  logic [32:0] res_valid_r;
  lmfc_mem_if mif();

  wire wr_pull = reg_wr_i && reg_addr_i == `LMFC_ADDR_PULL;
  wire wr_therm = reg_wr_i && reg_addr_i == `LMFC_ADDR_THERM;
  wire wr_spread = reg_wr_i && reg_addr_i == `LMFC_ADDR_SPREAD;
  wire soft_rst = reg_wr_i && reg_addr_i == `LMFC_ADDR_SRST && reg_wdata_i == `LMFC_SRST_KEY;
  wire res_hit = reg_addr_i >= `LMFC_ADDR_RES_FIRST && reg_addr_i <= `LMFC_ADDR_RES_LAST;
  wire [5:0] res_idx = 6'(reg_addr_i - `LMFC_ADDR_RES_FIRST);
  wire [7:0] rd_plain = (reg_addr_i == `LMFC_ADDR_PULL) ? pull_r : 8'h00;
  wire res_vld_nxt = res_hit && res_valid_r[res_idx];

  // power-up and the key write both load defaults
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pull_r <= `LMFC_PULL_RST;
      therm_r <= `LMFC_THERM_RST;
      spread_r <= `LMFC_SPREAD_RST;
    end else if (soft_rst) begin
      pull_r <= `LMFC_PULL_RST;
      therm_r <= `LMFC_THERM_RST;
      spread_r <= `LMFC_SPREAD_RST;
    end else begin
      if (wr_pull) pull_r <= reg_wdata_i;
      if (wr_therm) therm_r <= reg_wdata_i;
      if (wr_spread) spread_r <= reg_wdata_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rvalid_r <= 1'b0;
      rd_res_r <= 1'b0;
      res_vld_r <= 1'b0;
      rd_val_r <= 8'h00;
    end else begin
      rvalid_r <= reg_rd_i;
      rd_res_r <= reg_rd_i && res_hit;
      res_vld_r <= res_vld_nxt;
      rd_val_r <= rd_plain;
    end
  end

  assign mif.rd_addr = res_idx;
  assign reg_rvalid_o = rvalid_r;
  // result bytes: six flags low, top two bits zero
  assign reg_rdata_o = rd_res_r ? {2'b00, mif.rd_data & {6{res_vld_r}}} : rd_val_r;

  lmfc_result_mem u_mem (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .m(mif.mem)
  );

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  // a bit changes only once the second and third stages agree
  logic [19:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_f_r;
  wire [19:0] pin_raw = {sync_i, temp_hot_i, led_fault_i};
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_s1_r <= 20'h00000;
      pin_s2_r <= 20'h00000;
      pin_s3_r <= 20'h00000;
      pin_f_r <= 20'h00000;
    end else begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_f_r <= (pin_s2_r & pin_s3_r) | (pin_f_r & (pin_s2_r | pin_s3_r));
    end
  end
  wire [17:0] fault_f = pin_f_r[17:0];
  wire hot_f = pin_f_r[18];
  wire sync_f = pin_f_r[19];

  // ****************************************************************
  // row scan
  // ****************************************************************
  lmfc_scan_t state, state_nxt;
  logic [12:0] slot_cnt;
  logic [3:0] row_r;
  logic sync_prev_r, sync_seen_r, sync_out_r;
  wire master = spread_r[`LMFC_SYNC_HI:`LMFC_SYNC_LO] == 2'b11;
  wire slave = spread_r[`LMFC_SYNC_HI:`LMFC_SYNC_LO] == 2'b10;
  wire sync_rise = sync_f && !sync_prev_r;
  wire scan_end = state == LMFC_SCAN && slot_cnt == 13'(SCAN_CYC - 1);
  wire gap_end = state == LMFC_GAP && slot_cnt == 13'(NOL_CYC - 1);
  wire cdly_end = state == LMFC_CDLY && slot_cnt >= 13'(CDLY_CYC - 1);
  // a slave holds the next slot until the master's edge
  wire slot_go = cdly_end && (!slave || sync_seen_r);
  wire [3:0] row_next = (row_r == 4'(`LMFC_ROWS - 1)) ? 4'h0 : 4'(row_r + 4'h1);
  wire row0_start = slot_go && row_next == 4'h0;

  // scan period, then blanking gap, then column delay
  always_comb begin
    case (state)
      LMFC_SCAN: state_nxt = scan_end ? LMFC_GAP : LMFC_SCAN;
      LMFC_GAP: state_nxt = gap_end ? LMFC_CDLY : LMFC_GAP;
      LMFC_CDLY: state_nxt = slot_go ? LMFC_SCAN : LMFC_CDLY;
      default: state_nxt = LMFC_CDLY;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // start blank in the last row's gap so row 0 opens with its switch already set
      state <= LMFC_GAP;
      slot_cnt <= 13'h0000;
      row_r <= 4'(`LMFC_ROWS - 1);
    end else begin
      state <= state_nxt;
      slot_cnt <= (state_nxt != state) ? 13'h0000 : (cdly_end ? slot_cnt : 13'(slot_cnt + 13'h1));
      if (slot_go) row_r <= row_next;
    end
  end

  // seen edge set wins over its consumption
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_prev_r <= 1'b0;
      sync_seen_r <= 1'b0;
      sync_out_r <= 1'b0;
    end else begin
      sync_prev_r <= sync_f;
      sync_seen_r <= sync_rise || (sync_seen_r && !slot_go);
      sync_out_r <= state_nxt == LMFC_SCAN && slot_cnt < 13'(SCAN_CYC / 2);
    end
  end

  // master drives, slave listens, otherwise pulled low
  assign sync_oe_o = master;
  assign sync_o = master && sync_out_r;
  assign sync_pd_en_o = !spread_r[`LMFC_SYNC_HI];
  assign scan_row_o = row_r;

  // ****************************************************************
  // pwm columns
  // ****************************************************************
  logic [7:0] pwm_cnt;
  logic [12:0] pre_cnt;
  logic pwm_end_r;
  logic [10:0] row_sw_r;
  logic [17:0] col_r;
  logic [17:0] col_nxt;
  wire pre_wrap = pre_cnt == 13'(PWM_DIV - 1);
  // half-period offset of the on window
  wire [7:0] cnt_ph = pwm_cnt ^ {pull_r[`LMFC_PHASE_BIT], 7'h00};
  wire lit_ok = state == LMFC_SCAN && state_nxt == LMFC_SCAN && !pwm_end_r;

  for (genvar j = 0; j < 18; j++) begin : g_col
    // sink on while the counter is below the byte
    assign col_nxt[j] = lit_ok && cnt_ph < pwm_row_i[j*8 +: 8];
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pwm_cnt <= 8'h00;
      pre_cnt <= 13'h0000;
      pwm_end_r <= 1'b0;
      row_sw_r <= 11'h000;
      col_r <= 18'h00000;
    end else begin
      pre_cnt <= (state != LMFC_SCAN || pre_wrap) ? 13'h0000 : 13'(pre_cnt + 13'h1);
      if (state != LMFC_SCAN) begin
        pwm_cnt <= 8'h00;
        pwm_end_r <= 1'b0;
      end else if (pre_wrap) begin
        pwm_cnt <= 8'(pwm_cnt + 8'h01);
        if (pwm_cnt == 8'hFF) pwm_end_r <= 1'b1;
      end
      // one row high only while it is scanned
      row_sw_r <= (state_nxt == LMFC_SCAN) ? 11'(11'h001 << (slot_go ? row_next : row_r)) : 11'h000;
      col_r <= col_nxt;
    end
  end
  assign row_switch_o = row_sw_r;
  assign column_sink_o = col_r;

  // ****************************************************************
  // pull resistors
  // ****************************************************************
  wire [2:0] rpd_sel = pull_r[`LMFC_RPD_HI:`LMFC_RPD_LO];
  wire [2:0] cpu_sel = pull_r[`LMFC_CPU_HI:`LMFC_CPU_LO];
  // codes 1xx always on, 001-011 only while off
  assign row_pd_en_o = (rpd_sel == 3'h0) ? 11'h000 : (rpd_sel[2] ? 11'h7FF : ~row_sw_r);
  assign col_pu_en_o = (cpu_sel == 3'h0) ? 18'h00000 : (cpu_sel[2] ? 18'h3FFFF : ~col_r);
  assign row_pd_ohm_o = lmfc_ohm(rpd_sel);
  assign col_pu_ohm_o = lmfc_ohm(cpu_sel);

  // ****************************************************************
  // thermal and spread
  // ****************************************************************
  wire [1:0] thermal_derate = therm_r[`LMFC_THERMAL_DERATE_HI:`LMFC_THERMAL_DERATE_LO];
  assign thermal_limit_o = lmfc_temp(therm_r[`LMFC_TS_HI:`LMFC_TS_LO]);
  assign current_scale_o = hot_f ? lmfc_derate(thermal_derate) : lmfc_derate(2'h0);
  wire spread_enable = spread_r[`LMFC_SSP_BIT];
  // range and period stay zero unless spreading
  assign spread_en_o = spread_enable;
  assign spread_dev_o = spread_enable ? lmfc_dev(spread_r[`LMFC_RNG_HI:`LMFC_RNG_LO]) : 6'h00;
  assign spread_period_o = spread_enable ? lmfc_period(spread_r[`LMFC_CLT_HI:`LMFC_CLT_LO]) : 11'h000;

  // ****************************************************************
  // one-shot detection
  // ****************************************************************
  lmfc_det_t det_prev_r, det_kind_r;
  logic det_arm_r, det_run_r;
  logic [1:0] det_wcnt_r;
  logic [17:0] det_cap_r;
  // only an off-to-detect change starts a run
  wire det_trig = det_prev_r == LMFC_DET_OFF &&
                  (detect_mode_i == LMFC_DET_OPEN || detect_mode_i == LMFC_DET_SHORT);
  wire det_wr = det_wcnt_r != 2'h0;
  wire [1:0] det_k = 2'(det_wcnt_r - 2'h1);
  wire det_last = det_wcnt_r == 2'h3 && row_r == 4'(`LMFC_ROWS - 1);

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      det_prev_r <= LMFC_DET_OFF;
      det_kind_r <= LMFC_DET_OFF;
      det_arm_r <= 1'b0;
      det_run_r <= 1'b0;
      det_wcnt_r <= 2'h0;
      det_cap_r <= 18'h00000;
      res_valid_r <= 33'h0;
    end else begin
      det_prev_r <= lmfc_det_t'(detect_mode_i);
      if (det_trig) det_kind_r <= lmfc_det_t'(detect_mode_i);
      det_arm_r <= !soft_rst && (det_trig || (det_arm_r && !row0_start));
      det_run_r <= !soft_rst && ((det_arm_r && row0_start) || (det_run_r && !det_last));
      if (scan_end && det_run_r) det_cap_r <= fault_f;
      // a soft reset also stops pending writes so cleared results stay clear
      if (soft_rst) det_wcnt_r <= 2'h0;
      else if (scan_end && det_run_r) det_wcnt_r <= 2'h1;
      else if (det_wr) det_wcnt_r <= (det_wcnt_r == 2'h3) ? 2'h0 : 2'(det_wcnt_r + 2'h1);
      if (soft_rst) res_valid_r <= 33'h0;
      else if (det_wr) res_valid_r[mif.wr_addr] <= 1'b1;
    end
  end

  // three result bytes per row, written in the blanking gap
  assign mif.wr_en = det_wr;
  assign mif.wr_addr = 6'({row_r, 1'b0} + row_r + det_k);
  assign mif.wr_data = det_cap_r[det_k*6 +: 6];
  assign detect_kind_o = (det_run_r || det_arm_r) ? det_kind_r : LMFC_DET_OFF;
  assign detect_busy_o = det_run_r || det_arm_r;

  // ****************************************************************
  // checks
  // ****************************************************************
  row_onehot_a: assert property ($onehot0(row_switch_o))
    else $error("two rows enabled together");
  col_in_slot_a: assert property (row_switch_o == 11'h000 |-> column_sink_o == 18'h00000)
    else $error("column sink on outside a row slot");
  row_high_scan_a: assert property ((state == LMFC_SCAN) |-> row_switch_o != 11'h000)
    else $error("row switch low during its scan");
  gap_len_a: assert property ((state == LMFC_GAP && slot_cnt == 13'h0000) |-> ##NOL_CYC state == LMFC_CDLY)
    else $error("blanking gap has wrong length");
  pwm_zero_a: assert property ((pwm_row_i[7:0] == 8'h00) |=> !column_sink_o[0])
    else $error("zero pwm lit a column");
  row_pd_a: assert property ((rpd_sel inside {3'h1, 3'h2, 3'h3}) |-> (row_pd_en_o & row_switch_o) == 11'h000)
    else $error("off-time pull-down active on a lit row");
  col_pu_a: assert property ((cpu_sel == 3'h3 && column_sink_o[0]) |-> !col_pu_en_o[0] && col_pu_ohm_o == 14'h07D0)
    else $error("column pull-up wrong");
  srst_default_a: assert property (soft_rst |=> pull_r == `LMFC_PULL_RST && res_valid_r == 33'h0 && spread_r == 8'h00)
    else $error("soft reset left a register");
  res_upper_a: assert property (rd_res_r |-> reg_rdata_o[7:6] == 2'b00)
    else $error("result byte top bits set");
  therm_a: assert property ((hot_f && thermal_derate == 2'h3) |-> current_scale_o == 7'h1E)
    else $error("derate not applied");
  sync_off_a: assert property (!spread_r[`LMFC_SYNC_HI] |-> !sync_oe_o && sync_pd_en_o && !sync_o)
    else $error("sync pin not released");
  det_once_a: assert property ((!detect_busy_o && $stable(detect_mode_i) && !soft_rst) |=> !detect_busy_o)
    else $error("detection rerun without a new transition");
  spread_off_a: assert property (!spread_enable |-> spread_dev_o == 6'h00 && spread_period_o == 11'h000)
    else $error("spread fields active while disabled");

  det_done_c: cover property (det_run_r && det_last);
  slave_wait_c: cover property (slave && cdly_end && !sync_seen_r);
  master_c: cover property (master && sync_o);
  srst_c: cover property (soft_rst && res_valid_r != 33'h0);
endmodule

// ===== lmfc_far_model.sv
/* far-side model: brightness store and fault comparators of the matrix.
   assumes the design names its current scan row on scan_row_i. */
`timescale 1ns/100ps
module lmfc_far_model (
  // scan side
  input wire logic [3:0] scan_row_i,
  // toward the design
  output logic [143:0] pwm_row_o,
  output logic [17:0] led_fault_o
);
  // row 1 stays dark so a zero byte is exercised; other rows share one byte
  assign pwm_row_o = (scan_row_i == 4'h1) ? 144'h0 : {18{8'h40}};
  // uneven pattern so each result byte of a row differs
  assign led_fault_o = 18'h2A015;
endmodule

// ===== lmfc_tb_top.sv
/* self-checking bench: registers, pulls, thermal, sync, spread, scan, detection.
   assumes lmfc_far_model stands at the matrix side. */
`timescale 1ns/100ps
`include "lmfc_regs.svh"
module lmfc_tb_top;
  import lmfc_pkg::*;
  // ********
  // signals
  // ********
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} lmfc_row_t;
  logic core_clk_i = 0, rst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0, temp_hot_i = 0, sync_i = 0;
  logic [7:0] reg_addr_i = 0, reg_wdata_i = 0, reg_rdata_o, thermal_limit_o, v;
  logic reg_rvalid_o, detect_busy_o, sync_o, sync_oe_o, sync_pd_en_o, spread_en_o;
  logic [3:0] scan_row_o;
  logic [10:0] row_switch_o, row_pd_en_o, spread_period_o;
  logic [17:0] column_sink_o, col_pu_en_o, led_fault_i;
  logic [13:0] row_pd_ohm_o, col_pu_ohm_o;
  logic [1:0] detect_kind_o, detect_mode_i = 0;
  logic [6:0] current_scale_o;
  logic [5:0] spread_dev_o;
  logic [143:0] pwm_row_i;
  int fail_count = 0, cmp_count = 0, n, k, f;
  localparam int two_scans = 2 * `LMFC_ROWS * (512 + 166 + 60);
  lmfc_row_t rows[5] = '{'{8'h02, 8'hC5, 8'hC5}, '{8'h24, 8'h0E, 8'h00},
    '{8'h25, 8'h1B, 8'h00}, '{8'h10, 8'hFF, 8'h00}, '{8'h05, 8'hFF, 8'h00}};
  lmfc_top #(.ROW_SLOT_CYC(512)) lmfc_top_i (.core_clk_i, .rst_n_i, .reg_wr_i, .reg_rd_i,
    .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .detect_mode_i, .pwm_row_i,
    .scan_row_o, .row_switch_o, .column_sink_o, .row_pd_en_o, .row_pd_ohm_o, .col_pu_en_o,
    .col_pu_ohm_o, .led_fault_i, .detect_kind_o, .detect_busy_o, .temp_hot_i,
    .thermal_limit_o, .current_scale_o, .sync_i, .sync_o, .sync_oe_o, .sync_pd_en_o,
    .spread_en_o, .spread_dev_o, .spread_period_o);
  lmfc_far_model lmfc_far_model_i (.scan_row_i(scan_row_o), .pwm_row_o(pwm_row_i),
    .led_fault_o(led_fault_i));
  // ********
  // tasks
  // ********
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk_i) {reg_wr_i, reg_addr_i, reg_wdata_i} = {1'b1, a, d};
    @(negedge core_clk_i) reg_wr_i = 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge core_clk_i) {reg_rd_i, reg_addr_i} = {1'b1, a};
    @(negedge core_clk_i) reg_rd_i = 0;
    chk("rvalid", 1, reg_rvalid_o);
    v = reg_rdata_o;
  endtask
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // a bounded wait that ran out ends the run
  task automatic give_up(input int c);
    if (c >= 40000) begin
      fail_count++;
      end_of_test();
    end
  endtask
  task automatic detect(input logic [1:0] m);
    detect_mode_i = 0;
    repeat (2) @(negedge core_clk_i);
    detect_mode_i = m;
    repeat (2) @(negedge core_clk_i);
    chk("busy", 1, detect_busy_o);
    chk("kind", m, detect_kind_o);
    for (n = 0; (detect_busy_o !== 1'b0 || n < two_scans) && n < 40000; n++) @(negedge core_clk_i);
    give_up(n);
    rd(8'h03);
    chk("first byte", 8'h15, v);
    rd(8'h23);
    chk("last byte", 8'h2A, v);
  endtask
  // ********
  // sequence
  // ********
  initial begin
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  initial begin
    repeat (6) @(negedge core_clk_i);
    rst_n_i = 1;
    rd(`LMFC_ADDR_PULL);
    chk("pull default", `LMFC_PULL_RST, v);
    chk("sync pull low", 1, sync_pd_en_o);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      chk("readback", rows[i].e, v);
    end
    chk("row ohm", 14'h03E8, row_pd_ohm_o);
    chk("row always", 11'h7FF, row_pd_en_o);
    chk("col ohm", 14'h07D0, col_pu_ohm_o);
    chk("limit", 8'h5A, thermal_limit_o);
    chk("cool", 7'h64, current_scale_o);
    temp_hot_i = 1;
    repeat (6) @(negedge core_clk_i);
    chk("hot", 7'h37, current_scale_o);
    temp_hot_i = 0;
    chk("spread", 1, spread_en_o);
    chk("dev", 6'h18, spread_dev_o);
    chk("period", 11'h294, spread_period_o);
    wr(`LMFC_ADDR_SPREAD, 8'h8B);
    chk("dev off", 0, spread_dev_o);
    chk("slave", 2'b00, {sync_oe_o, sync_pd_en_o});
    repeat (800) @(negedge core_clk_i);
    chk("slave hold", 0, row_switch_o);
    sync_i = 1;
    repeat (8) @(negedge core_clk_i);
    chk("slave go", 1, row_switch_o != 11'h000);
    sync_i = 0;
    wr(`LMFC_ADDR_SPREAD, 8'hC0);
    chk("master", 2'b10, {sync_oe_o, sync_pd_en_o});
    for (n = 0; row_switch_o === 11'h000 && n < 40000; n++) @(negedge core_clk_i);
    give_up(n);
    chk("sync drive", 1, sync_o);
    wr(`LMFC_ADDR_SRST, 8'h00);
    rd(`LMFC_ADDR_PULL);
    chk("wrong key", 8'hC5, v);
    wr(`LMFC_ADDR_SRST, `LMFC_SRST_KEY);
    rd(`LMFC_ADDR_PULL);
    chk("soft reset", `LMFC_PULL_RST, v);
    chk("sync reset", 1, sync_pd_en_o);
    for (int p = 0; p < 2; p++) begin
      wr(`LMFC_ADDR_PULL, p ? 8'hB3 : 8'h33);
      for (k = 0; row_switch_o[0] !== 1'b0 && k < 40000; k++) @(negedge core_clk_i);
      give_up(k);
      for (n = 0; row_switch_o[0] !== 1'b1 && n < 40000; n++) @(negedge core_clk_i);
      k = 0;
      f = -1;
      for (int c = 0; row_switch_o[0] === 1'b1 && n < 40000; c++) begin
        if (column_sink_o[0] === 1'b1 && f < 0) f = c;
        k += column_sink_o[0];
        chk("one row", 1, $onehot(row_switch_o));
        chk("row pd off", 0, row_pd_en_o[0]);
        chk("col pu", !column_sink_o[0], col_pu_en_o[0]);
        @(negedge core_clk_i);
        n++;
      end
      give_up(n);
      chk("on time", 128, k);
      chk("phase", 1, p ? f >= 256 : f < 8);
    end
    detect(2'b01);
    detect_mode_i = 2'b10;
    repeat (3) @(negedge core_clk_i);
    chk("no retrigger", 0, detect_busy_o);
    detect(2'b10);
    end_of_test();
  end
endmodule
